// ===== rtl/frsh_defs.vh
// Constants for the result status and host handshake block.
// Assumes a 40 MHz clock and a three-bit register address from the host.
`ifndef FRSH_DEFS_VH
`define FRSH_DEFS_VH

// Register addresses on the host port.
`define FRSH_A_DRIVE_CTRL   3'h2
`define FRSH_A_MAIN_STAT    3'h4
`define FRSH_A_RATE_SEL     3'h4
`define FRSH_A_DATA         3'h5
`define FRSH_A_DISK_CHG     3'h7

// Reset values.
`define FRSH_DCR_RESET      8'h00
`define FRSH_DRR_RESET      2'h2

// Drive control field positions.
`define FRSH_DCR_DMA        3
`define FRSH_DCR_RUN        2

// Main status field positions.
`define FRSH_MS_RQM         7
`define FRSH_MS_DIO         6
`define FRSH_MS_NDMA        5
`define FRSH_MS_BUSY        4

// Termination codes.
`define FRSH_TERM_NORMAL    2'h0
`define FRSH_TERM_ABNORMAL  2'h1
`define FRSH_TERM_INVALID   2'h2
`define FRSH_TERM_READY     2'h3

// Result sequence kinds.
`define FRSH_RES_NONE       2'h0
`define FRSH_RES_SENSE      2'h1
`define FRSH_RES_DRIVE      2'h2
`define FRSH_RES_FULL       2'h3

// Service time limits in nanoseconds and the clock period.
`define FRSH_CLK_NS         25
`define FRSH_SVC_125_NS     62000
`define FRSH_SVC_250_NS     30000
`define FRSH_SVC_500_NS     14000
`define FRSH_SVC_1000_NS    6000
`define FRSH_SVC_125_CYC    (`FRSH_SVC_125_NS / `FRSH_CLK_NS)
`define FRSH_SVC_250_CYC    (`FRSH_SVC_250_NS / `FRSH_CLK_NS)
`define FRSH_SVC_500_CYC    (`FRSH_SVC_500_NS / `FRSH_CLK_NS)
`define FRSH_SVC_1000_CYC   (`FRSH_SVC_1000_NS / `FRSH_CLK_NS)

`endif

// ===== rtl/frsh_core.v
// Result status assembly, phase sequencing and host byte handshake.
// Assumes host strobes synchronous to i_clk; the command core decodes.
//
// Operation
// - Seek-complete sets status 0 bit 5.
// - Recalibrate without track zero sets status 0 bit 4.
// - Status 0 bit 3 zero, bit 2 head, bits 1-0 drive.
// - Last byte of last sector without transfer end sets end-of-track.
// - CRC error sets status 1 bit 5; data field also status 2 bit 5.
// - Late service of an execution byte sets overrun.
// - Absent sector, bad identify or missing start sector set no-data.
// - Write protect at write or format issue sets not-writable.
// - Missing address mark sets status 1 bit 0; data mark also status 2.
// - Wrong kind of data mark sets control-mark.
// - Track mismatch sets wrong-track; recorded FF also bad-track.
// - Scan equal sets bit 3; unsatisfied scan sets bit 2.
// - Status 3 is 0, protect, 1, track zero, 0, head, drive.
// - Command bytes in order; execution starts on the final byte.
// - Result bytes leave in a fixed order.
// - Command writes only while main status bit 6 clear, bit 7 set.
// - Core held idle while drive control bit 2 is clear; rate writes set the service limit.
// - Status 0 bits 7-6 hold the termination code.
// - Disk change bit 7 is the inverse registered every cycle; bits 6-0 undriven.
`timescale 1ns/10ps
`include "frsh_defs.vh"

// Command byte buffer between the host port and the command core.
module frsh_fifo
#(
	parameter WIDTH = 8,
	parameter DEPTH = 4,
	parameter AW    = 2
)
(
	input  wire             i_clk,
	input  wire             i_reset,
	input  wire             i_clear,
	input  wire             i_in_valid,
	input  wire [WIDTH-1:0] i_in_data,
	output reg              o_in_ready,
	output reg              o_out_valid,
	output wire [WIDTH-1:0] o_out_data,
	input  wire             i_out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	reg [AW:0]      next_count;
	wire            push;
	wire            pop;

	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;
	assign o_out_data = mem[rd_ptr];

	// Occupancy after this cycle's push and pop.
	always @*
	begin
		next_count = count;
		if (push & ~pop)
			next_count = count + 1'b1;
		else if (pop & ~push)
			next_count = count - 1'b1;
	end

	// Pointers, storage and registered full and empty flags.
	always @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			o_in_ready <= 1'b1;
			o_out_valid <= 1'b0;
		end
		else if (i_clear)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			o_in_ready <= 1'b1;
			o_out_valid <= 1'b0;
		end
		else
		begin
			if (push)
			begin
				mem[wr_ptr] <= i_in_data;
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
			count <= next_count;
			o_in_ready <= (next_count != DEPTH[AW:0]);
			o_out_valid <= (next_count != {(AW+1){1'b0}});
		end
	end
endmodule // frsh_fifo

// Host register port, phase sequencer and result status bytes.
module frsh_core
(
	input  wire       i_clk,
	input  wire       i_reset,
	input  wire       i_cs_n,
	input  wire       i_rd_n,
	input  wire       i_wr_n,
	input  wire [2:0] i_addr,
	input  wire [7:0] i_data,
	output reg  [7:0] o_data,
	output reg  [7:0] o_data_oe_n,
	output reg  [3:0] o_motor_en,
	output reg  [1:0] o_drive_sel,
	output reg        o_dma_en,
	output reg        o_core_reset,
	output reg  [1:0] o_data_rate,
	output reg        o_disk_changed,
	input  wire       i_media_change_n,
	input  wire [3:0] i_cmd_len,
	output reg        o_exec_start,
	output wire       o_cmd_valid,
	output wire [7:0] o_cmd_data,
	input  wire       i_cmd_ready,
	input  wire       i_is_seek,
	input  wire       i_is_write,
	input  wire       i_non_dma,
	input  wire       i_xfer_req,
	input  wire       i_xfer_to_host,
	input  wire [7:0] i_xfer_data,
	output reg  [7:0] o_xfer_wdata,
	output reg        o_xfer_done,
	output reg        o_dma_request,
	input  wire       i_dma_ack_n,
	input  wire       i_transfer_end,
	input  wire       i_ev_seek_end,
	input  wire       i_ev_recal_fail,
	input  wire       i_ev_last_byte,
	input  wire       i_ev_crc_addr,
	input  wire       i_ev_crc_data,
	input  wire       i_ev_no_data,
	input  wire       i_ev_miss_addr,
	input  wire       i_ev_miss_data,
	input  wire       i_ev_ctrl_mark,
	input  wire       i_ev_track_diff,
	input  wire [7:0] i_rec_track,
	input  wire       i_ev_scan_equal,
	input  wire       i_ev_scan_fail,
	input  wire       i_write_protect,
	input  wire       i_track_zero,
	input  wire       i_head,
	input  wire [1:0] i_drive,
	input  wire       i_exec_done,
	input  wire [1:0] i_term_code,
	input  wire [1:0] i_res_mode,
	input  wire [7:0] i_res_track,
	input  wire [31:0] i_res_id
);
	localparam P_IDLE = 2'h0;
	localparam P_CMD  = 2'h1;
	localparam P_EXEC = 2'h2;
	localparam P_RES  = 2'h3;

	reg  [1:0]  phase;
	reg  [3:0]  cmd_cnt;
	reg  [3:0]  cmd_len;
	reg  [2:0]  res_idx;
	reg  [2:0]  res_last;
	reg  [1:0]  res_mode;
	reg         rd_q;
	reg         wr_q;
	reg         ack_q;
	reg         run;
	reg  [3:0]  seeking;
	reg         pending;
	reg  [11:0] svc_cnt;
	reg         tc_seen;
	reg  [1:0]  term;
	reg         head;
	reg  [1:0]  drive;
	reg  [7:0]  st1;
	reg  [7:0]  st2;
	reg         seek_end;
	reg         eq_check;
	reg  [7:0]  st3;
	reg  [7:0]  main_status;
	wire        rd_go;
	wire        wr_go;
	wire        ack_go;
	wire        dat;
	wire        fifo_ready;
	wire        cmd_push;
	wire        svc;
	wire        cmd_last;
	wire [7:0]  st0;

	// Service limits in cycles, cut to the timer width on use.
	localparam [31:0] LIM_250  = `FRSH_SVC_250_CYC;
	localparam [31:0] LIM_500  = `FRSH_SVC_500_CYC;
	localparam [31:0] LIM_1000 = `FRSH_SVC_1000_CYC;

	// Service limit for the selected data rate.
	function [11:0] svc_limit;
		input [1:0] rate;
		begin
			case (rate)
			2'h0: svc_limit = LIM_500[11:0];
			2'h3: svc_limit = LIM_1000[11:0];
			default: svc_limit = LIM_250[11:0];
			endcase
		end
	endfunction

	// Strobe edges; an access acts on the falling edge of its strobe.
	assign rd_go = ~i_cs_n & ~i_rd_n & rd_q;
	assign wr_go = ~i_cs_n & ~i_wr_n & wr_q;
	assign ack_go = ~i_dma_ack_n & ack_q;
	assign dat = (i_addr == `FRSH_A_DATA);
	assign cmd_push = wr_go & dat & fifo_ready & run &
		((phase == P_IDLE) | (phase == P_CMD));
	assign svc = pending & (((rd_go | wr_go) & dat) |
		(ack_go & o_dma_en));
	// Final command byte, also when the command is a single byte.
	assign cmd_last = ((phase == P_IDLE) & (i_cmd_len <= 4'h1)) |
		((phase == P_CMD) & (cmd_cnt + 1'b1 >= cmd_len));

	assign st0 = {term, seek_end, eq_check, 1'b0,
		head, drive};

	// Result byte by position; order is fixed per result kind.
	function [7:0] res_byte;
		input [2:0] idx;
		begin
			case (idx)
			3'h0: res_byte = (res_mode == `FRSH_RES_DRIVE) ? st3 : st0;
			3'h1: res_byte = (res_mode == `FRSH_RES_SENSE) ?
				i_res_track : st1;
			3'h2: res_byte = st2;
			3'h3: res_byte = i_res_id[31:24];
			3'h4: res_byte = i_res_id[23:16];
			3'h5: res_byte = i_res_id[15:8];
			3'h6: res_byte = i_res_id[7:0];
			default: res_byte = 8'h00;
			endcase
		end
	endfunction

	// Host command bytes pass through a small buffer to the core.
	frsh_fifo #(.WIDTH(8), .DEPTH(4), .AW(2)) u_fifo
	(
		.i_clk       (i_clk),
		.i_reset     (i_reset),
		.i_clear     (~run),
		.i_in_valid  (cmd_push),
		.i_in_data   (i_data),
		.o_in_ready  (fifo_ready),
		.o_out_valid (o_cmd_valid),
		.o_out_data  (o_cmd_data),
		.i_out_ready (i_cmd_ready)
	);

	// Drive control, rate select and disk change; hardware reset only.
	always @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			rd_q <= 1'b1;
			wr_q <= 1'b1;
			ack_q <= 1'b1;
			o_motor_en <= 4'h0;
			o_drive_sel <= 2'h0;
			o_dma_en <= 1'b0;
			run <= 1'b0;
			o_core_reset <= 1'b1;
			o_data_rate <= `FRSH_DRR_RESET;
			o_disk_changed <= 1'b0;
		end
		else
		begin
			rd_q <= i_cs_n | i_rd_n;
			wr_q <= i_cs_n | i_wr_n;
			ack_q <= i_dma_ack_n;
			o_disk_changed <= ~i_media_change_n;
			o_core_reset <= ~run;
			if (wr_go & (i_addr == `FRSH_A_DRIVE_CTRL))
			begin
				o_motor_en <= i_data[7:4];
				o_dma_en <= i_data[`FRSH_DCR_DMA];
				run <= i_data[`FRSH_DCR_RUN];
				o_drive_sel <= i_data[1:0];
			end
			if (wr_go & (i_addr == `FRSH_A_RATE_SEL))
				o_data_rate <= i_data[1:0];
		end
	end

	// Phase sequencing, byte counts and the execution service timer.
	always @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			phase <= P_IDLE;
			cmd_cnt <= 4'h0;
			cmd_len <= 4'h0;
			res_idx <= 3'h0;
			res_last <= 3'h0;
			res_mode <= `FRSH_RES_NONE;
			o_exec_start <= 1'b0;
			seeking <= 4'h0;
			pending <= 1'b0;
			svc_cnt <= 12'h000;
			o_xfer_done <= 1'b0;
			o_xfer_wdata <= 8'h00;
			o_dma_request <= 1'b0;
		end
		else if (~run)
		begin
			phase <= P_IDLE;
			cmd_cnt <= 4'h0;
			res_idx <= 3'h0;
			o_exec_start <= 1'b0;
			seeking <= 4'h0;
			pending <= 1'b0;
			o_xfer_done <= 1'b0;
			o_dma_request <= 1'b0;
		end
		else
		begin
			o_exec_start <= 1'b0;
			o_xfer_done <= svc;
			if (cmd_push)
			begin
				cmd_cnt <= cmd_cnt + 1'b1;
				phase <= P_CMD;
				if (phase == P_IDLE)
					cmd_len <= i_cmd_len;
				if (cmd_last)
				begin
					phase <= P_EXEC;
					o_exec_start <= 1'b1;
					cmd_cnt <= 4'h0;
					if (i_is_seek)
						seeking[i_drive] <= 1'b1;
				end
			end
			if ((phase == P_EXEC) & svc & wr_go)
				o_xfer_wdata <= i_data;
			// A byte request starts the service timer.
			if ((phase == P_EXEC) & i_xfer_req)
			begin
				pending <= 1'b1;
				svc_cnt <= 12'h000;
			end
			else if (svc | (svc_cnt == svc_limit(o_data_rate)))
				pending <= 1'b0;
			else if (pending)
				svc_cnt <= svc_cnt + 1'b1;
			o_dma_request <= pending & ~svc & o_dma_en & ~i_non_dma;
			if ((phase == P_EXEC) & i_exec_done)
			begin
				pending <= 1'b0;
				res_idx <= 3'h0;
				res_mode <= i_res_mode;
				case (i_res_mode)
				`FRSH_RES_NONE: phase <= P_IDLE;
				`FRSH_RES_SENSE: res_last <= 3'h1;
				`FRSH_RES_DRIVE: res_last <= 3'h0;
				default: res_last <= 3'h6;
				endcase
				if (i_res_mode != `FRSH_RES_NONE)
					phase <= P_RES;
			end
			// Each data port read hands out the next result byte.
			if ((phase == P_RES) & rd_go & dat)
			begin
				res_idx <= res_idx + 1'b1;
				if ((res_idx == 3'h0) & (res_mode == `FRSH_RES_SENSE))
					seeking[drive] <= 1'b0;
				if (res_idx == res_last)
					phase <= P_IDLE;
			end
		end
	end

	// Status flags; a new command clears them, events during execution set.
	always @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			term <= `FRSH_TERM_NORMAL;
			seek_end <= 1'b0;
			eq_check <= 1'b0;
			st1 <= 8'h00;
			st2 <= 8'h00;
			st3 <= 8'h20;
			head <= 1'b0;
			drive <= 2'h0;
			tc_seen <= 1'b0;
		end
		else
		begin
			if (cmd_push & (phase == P_IDLE))
			begin
				seek_end <= 1'b0;
				eq_check <= 1'b0;
				st1 <= 8'h00;
				st2 <= 8'h00;
				tc_seen <= 1'b0;
			end
			if (i_transfer_end & ~i_dma_ack_n)
				tc_seen <= 1'b1;
			if (phase == P_EXEC)
			begin
				if (i_ev_seek_end)
					seek_end <= 1'b1;
				if (i_ev_recal_fail)
					eq_check <= 1'b1;
				if (i_ev_last_byte & ~tc_seen &
					~(i_transfer_end & ~i_dma_ack_n))
					st1[7] <= 1'b1;
				if (i_ev_crc_addr | i_ev_crc_data)
					st1[5] <= 1'b1;
				if (i_ev_crc_data)
					st2[5] <= 1'b1;
				if (pending & ~svc & (svc_cnt == svc_limit(o_data_rate)))
					st1[4] <= 1'b1;
				if (i_ev_no_data)
					st1[2] <= 1'b1;
				if (i_ev_miss_addr | i_ev_miss_data)
					st1[0] <= 1'b1;
				if (i_ev_miss_data)
					st2[0] <= 1'b1;
				if (i_ev_ctrl_mark)
					st2[6] <= 1'b1;
				if (i_ev_track_diff)
					st2[4] <= 1'b1;
				if (i_ev_track_diff & (i_rec_track == 8'hFF))
					st2[1] <= 1'b1;
				if (i_ev_scan_equal)
					st2[3] <= 1'b1;
				if (i_ev_scan_fail)
					st2[2] <= 1'b1;
			end
			// Protect state is judged when the command is issued.
			if (cmd_push & cmd_last & i_is_write & i_write_protect)
				st1[1] <= 1'b1;
			if ((phase == P_EXEC) & i_exec_done)
			begin
				term <= i_term_code;
				head <= i_head;
				drive <= i_drive;
				st3 <= {1'b0, i_write_protect, 1'b1, i_track_zero,
					1'b0, i_head, i_drive};
			end
		end
	end

	// Main status word, rebuilt every cycle from the phase.
	always @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			main_status <= 8'h00;
		else
		begin
			main_status[3:0] <= seeking;
			main_status[`FRSH_MS_BUSY] <= (phase != P_IDLE);
			main_status[`FRSH_MS_NDMA] <= (phase == P_EXEC) & i_non_dma;
			main_status[`FRSH_MS_DIO] <= (phase == P_RES) |
				((phase == P_EXEC) & i_xfer_to_host);
			main_status[`FRSH_MS_RQM] <= run & ~(rd_go | wr_go) &
				(((phase == P_IDLE) | (phase == P_CMD)) ? fifo_ready :
				(phase == P_RES) ? 1'b1 :
				(pending & i_non_dma));
		end
	end

	// Read data and per-bit drive enables for the host data bus.
	always @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
		begin
			o_data <= 8'h00;
			o_data_oe_n <= 8'hFF;
		end
		else if (i_cs_n | i_rd_n)
			o_data_oe_n <= 8'hFF;
		else if (rd_go)
		begin
			o_data_oe_n <= 8'h00;
			o_data <= 8'h00;
			case (i_addr)
			`FRSH_A_MAIN_STAT: o_data <= main_status;
			`FRSH_A_DATA: o_data <= (phase == P_RES) ? res_byte(res_idx) :
				i_xfer_data;
			`FRSH_A_DISK_CHG:
			begin
				o_data <= {o_disk_changed, 7'h00};
				o_data_oe_n <= 8'h7F;
			end
			default: o_data_oe_n <= 8'hFF;
			endcase
		end
	end
endmodule // frsh_core

// ===== tb/frsh_core_assertions.sv
// Concurrent checks on the host port of the result and handshake block.
// Assumes it is bound to frsh_core and sees only that module's ports.
`timescale 1ns/10ps
module frsh_chk
(
	input wire logic       i_clk,
	input wire logic       i_reset,
	input wire logic       i_cs_n,
	input wire logic       i_rd_n,
	input wire logic       i_wr_n,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_data,
	input wire logic [7:0] o_data,
	input wire logic [7:0] o_data_oe_n,
	input wire logic [1:0] o_drive_sel,
	input wire logic       o_core_reset,
	input wire logic [1:0] o_data_rate,
	input wire logic       o_disk_changed,
	input wire logic       i_media_change_n,
	input wire logic       o_exec_start
);
	// Decoded host strobes.
	wire wr_go = !i_cs_n && !i_wr_n;
	wire rd_go = !i_cs_n && !i_rd_n;
	wire dwr   = wr_go && (i_addr == 3'h5);

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	// Reset state and control register writes.
	AST_RESET_VAL: assert property ($fell(i_reset) |->
		o_data_rate == 2'h2 && o_core_reset && o_data_oe_n == 8'hFF)
		else $error("reset state wrong");
	AST_DCTL_WR: assert property (
		(wr_go && i_addr == 3'h2 && $past(i_wr_n)) ##1 wr_go |->
		o_drive_sel == i_data[1:0] ##1
		o_core_reset == !$past(i_data[2]))
		else $error("drive control not applied");
	AST_RATE_WR: assert property (
		(wr_go && i_addr == 3'h4 && $past(i_wr_n)) ##1 wr_go |->
		o_data_rate == i_data[1:0])
		else $error("data rate not applied");

	// Execution starts only from a data port write and lasts one cycle.
	AST_EXEC_CAUSE: assert property (o_exec_start |-> $past(dwr))
		else $error("execution start without command write");
	AST_EXEC_PULSE: assert property (o_exec_start |=> !o_exec_start)
		else $error("execution start longer than one cycle");

	// Read port drive enables and the disk change bit.
	AST_MSR_DRIVE: assert property (
		(rd_go && i_addr == 3'h4)[*2] |-> o_data_oe_n == 8'h00)
		else $error("main status not driven");
	AST_UNMAPPED: assert property (
		(rd_go && i_addr == 3'h0)[*2] |-> o_data_oe_n == 8'hFF)
		else $error("unmapped read drives the bus");
	AST_DKR_READ: assert property (
		(rd_go && i_addr == 3'h7)[*2] |->
		o_data_oe_n == 8'h7F && o_data[7] == o_disk_changed)
		else $error("disk change read wrong");
	AST_DKR_SET: assert property (
		(!i_media_change_n)[*3] |-> o_disk_changed)
		else $error("disk change not latched");
	AST_FLOAT: assert property (i_rd_n[*3] |-> o_data_oe_n == 8'hFF)
		else $error("bus driven without read");

	// Main scenarios reached.
	CVR_EXEC: cover property (o_exec_start);
	CVR_DKR: cover property ((rd_go && i_addr == 3'h7)[*2]);
	CVR_DCTL: cover property ((wr_go && i_addr == 3'h2) ##1 wr_go);
endmodule // frsh_chk

// ===== tb/frsh_host.sv
// Host processor model driving the register port with strobes.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/10ps
module frsh_host
(
	input  wire logic       i_clk,
	output logic            o_cs_n,
	output logic            o_rd_n,
	output logic            o_wr_n,
	output logic [2:0]      o_addr,
	output logic [7:0]      o_data,
	input  wire logic [7:0] i_rdata,
	input  wire logic [7:0] i_oe_n
);
	// Idle bus with no strobe active.
	initial
	begin
		o_cs_n = 1'h1;
		o_rd_n = 1'h1;
		o_wr_n = 1'h1;
		o_addr = 3'h0;
		o_data = 8'h00;
	end

	// Write one byte over two edges, then leave one idle cycle.
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge i_clk);
		o_cs_n = 1'h0;
		o_wr_n = 1'h0;
		o_addr = a;
		o_data = d;
		repeat (2) @(negedge i_clk);
		o_cs_n = 1'h1;
		o_wr_n = 1'h1;
		o_data = ~d; // Released lines show the inverse value.
		@(negedge i_clk);
	endtask

	// Read one byte; data and enables are taken before the strobe ends.
	task automatic rd(input logic [2:0] a, output logic [7:0] d,
		output logic [7:0] oe);
		@(negedge i_clk);
		o_cs_n = 1'h0;
		o_rd_n = 1'h0;
		o_addr = a;
		repeat (2) @(negedge i_clk);
		d = i_rdata;
		oe = i_oe_n;
		o_cs_n = 1'h1;
		o_rd_n = 1'h1;
		@(negedge i_clk);
	endtask
endmodule // frsh_host

// ===== tb/testbench.sv
// Self-checking bench for the result status and host handshake block.
// Assumes a 40 MHz clock; the bench plays the command core itself.
`timescale 1ns/10ps
module testbench;
	logic        i_clk = 1'h0;
	logic        i_reset = 1'h1;
	logic        i_media_change_n = 1'h1;
	logic        i_is_seek = 1'h0;
	logic        i_is_write = 1'h0;
	logic        i_dma_ack_n = 1'h1;
	logic        i_transfer_end = 1'h0;
	logic        i_write_protect = 1'h0;
	logic        i_track_zero = 1'h0;
	logic        i_head = 1'h0;
	logic        i_exec_done = 1'h0;
	logic [1:0]  i_drive = 2'h0;
	logic [1:0]  i_term_code = 2'h0;
	logic [1:0]  i_res_mode = 2'h0;
	logic [3:0]  i_cmd_len = 4'h1;
	logic [7:0]  i_rec_track = 8'hFF;
	logic [7:0]  i_res_track = 8'h00;
	logic [31:0] i_res_id = 32'h0;
	logic [11:0] ev = 12'h000;
	logic        i_non_dma = 1'h0;
	logic        i_xfer_req = 1'h0;
	logic        i_xfer_to_host = 1'h0;
	logic [7:0]  i_xfer_data = 8'h5A;
	int          n_done = 0;
	int          error_cnt = 0;
	int          compares = 0;
	int          n_exec = 0;
	wire         i_cs_n, i_rd_n, i_wr_n, o_dma_en, o_core_reset;
	wire         o_disk_changed, o_exec_start, o_cmd_valid;
	wire         o_xfer_done, o_dma_request;
	wire [2:0]   i_addr;
	wire [3:0]   o_motor_en;
	wire [1:0]   o_drive_sel, o_data_rate;
	wire [7:0]   i_data, o_data, o_data_oe_n, o_cmd_data, o_xfer_wdata;

	// Clock at 25 ns period.
	always #12.5 i_clk = ~i_clk;

	// Count execution start and byte done pulses.
	always @(posedge i_clk)
	begin
		if (o_exec_start === 1'h1)
			n_exec <= n_exec + 1;
		if (o_xfer_done === 1'h1)
			n_done <= n_done + 1;
	end

	frsh_core DUT (.*, .i_cmd_ready(1'h1),
		.i_ev_seek_end(ev[11]), .i_ev_recal_fail(ev[10]),
		.i_ev_last_byte(ev[9]), .i_ev_crc_addr(ev[8]),
		.i_ev_crc_data(ev[7]), .i_ev_no_data(ev[6]),
		.i_ev_miss_addr(ev[5]), .i_ev_miss_data(ev[4]),
		.i_ev_ctrl_mark(ev[3]), .i_ev_track_diff(ev[2]),
		.i_ev_scan_equal(ev[1]), .i_ev_scan_fail(ev[0]));

	frsh_host host (.i_clk, .o_cs_n(i_cs_n), .o_rd_n(i_rd_n),
		.o_wr_n(i_wr_n), .o_addr(i_addr), .o_data(i_data),
		.i_rdata(o_data), .i_oe_n(o_data_oe_n));

	// Compare one value and count the outcome.
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	// Print the counts and the verdict, then stop.
	task automatic summarize;
		$display("compares %0d, errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Execution bytes: one served in time, one left until overrun.
	task automatic xfer;
		logic [7:0] d;
		logic [7:0] oe;
		int         nd;
		nd = n_done;
		@(negedge i_clk);
		i_xfer_req = 1'h1;
		@(negedge i_clk);
		i_xfer_req = 1'h0;
		host.rd(3'h4, d, oe);
		check(d, 8'hF0);
		host.rd(3'h5, d, oe);
		check(d, 8'h5A);
		check(8'(n_done - nd), 8'h01);
		@(negedge i_clk);
		i_xfer_req = 1'h1;
		@(negedge i_clk);
		i_xfer_req = 1'h0;
		repeat (200) @(negedge i_clk);
		host.rd(3'h4, d, oe);
		check(d, 8'hF0);
		repeat (60) @(negedge i_clk);
	endtask

	// Issue one command, pulse events, end execution and read results.
	task automatic run(input string nm, input logic [11:0] e,
		input logic [1:0] term, input logic [1:0] mode,
		input logic [55:0] exp, input int n, input logic [7:0] mx);
		logic [7:0] d;
		logic [7:0] oe;
		int         k;
		int         ne;
		ne = n_exec;
		for (k = 0; k < i_cmd_len; k++)
			host.wr(3'h5, 8'h40 + 8'(k));
		check(8'(n_exec - ne), 8'h01);
		host.rd(3'h4, d, oe);
		check(d, mx);
		if (i_non_dma)
			xfer;
		@(negedge i_clk);
		ev = e;
		@(negedge i_clk);
		ev = 12'h000;
		i_exec_done = 1'h1;
		i_term_code = term;
		i_res_mode = mode;
		@(negedge i_clk);
		i_exec_done = 1'h0;
		d = 8'h00;
		for (k = 0; k < 8 && d[7] !== 1'h1; k++)
			host.rd(3'h4, d, oe);
		if (d[7] !== 1'h1)
		begin
			error_cnt++;
			$display("[ERR] %0t ns: result phase never came", $time);
			summarize;
		end
		check(d, (mx & 8'h1F) | 8'hC0);
		for (k = 0; k < n; k++)
		begin
			host.rd(3'h5, d, oe);
			check(d, exp[55 - 8 * k -: 8]);
		end
		host.rd(3'h4, d, oe);
		check(d, 8'h80);
		$display("%s test done", nm);
	endtask

	// Reset values, control registers, unmapped and status reads.
	task automatic t_regs;
		logic [7:0] d;
		logic [7:0] oe;
		check({6'h0, o_data_rate}, 8'h02);
		check({7'h0, o_core_reset}, 8'h01);
		host.wr(3'h2, 8'h25);
		check({o_motor_en, o_dma_en, o_core_reset, o_drive_sel}, 8'h21);
		host.wr(3'h4, 8'h03);
		check({6'h0, o_data_rate}, 8'h03);
		host.rd(3'h0, d, oe);
		check(oe, 8'hFF);
		host.rd(3'h4, d, oe);
		check(d, 8'h80);
		check(oe, 8'h00);
		$display("register test done");
	endtask

	// Disk change bit reads as the inverse, other bits released.
	task automatic t_dkr;
		logic [7:0] d;
		logic [7:0] oe;
		i_media_change_n = 1'h0;
		host.rd(3'h7, d, oe);
		check(oe, 8'h7F);
		check({7'h0, d[7]}, 8'h01);
		i_media_change_n = 1'h1;
		$display("disk change test done");
	endtask

	// Full results after abnormal end with many flags.
	task automatic t_full;
		i_cmd_len = 4'h2;
		i_head = 1'h1;
		i_drive = 2'h2;
		i_res_id = 32'h11223344;
		run("full", 12'h28E, 2'h1, 2'h3, {8'h46, 8'hA0, 8'h7A, i_res_id}, 7, 8'h10);
	endtask

	// New command clears old flags; write protect and end of transfer.
	task automatic t_clear;
		i_cmd_len = 4'h1;
		i_is_write = 1'h1;
		i_write_protect = 1'h1;
		i_head = 1'h0;
		i_drive = 2'h1;
		i_dma_ack_n = 1'h0;
		i_transfer_end = 1'h1;
		i_res_id = 32'hA5C30F96;
		run("clear", 12'h371, 2'h0, 2'h3, {8'h01, 8'h27, 8'h05, i_res_id}, 7, 8'h10);
		i_is_write = 1'h0;
		i_write_protect = 1'h0;
		i_dma_ack_n = 1'h1;
		i_transfer_end = 1'h0;
	endtask

	// Seek end and equipment check through the sense results.
	task automatic t_sense;
		i_is_seek = 1'h1;
		i_drive = 2'h3;
		i_res_track = 8'h4D;
		run("sense", 12'hC00, 2'h1, 2'h1, {8'h73, 8'h4D, 40'h0}, 2, 8'h18);
		i_is_seek = 1'h0;
	endtask

	// Drive state byte.
	task automatic t_st3;
		i_write_protect = 1'h1;
		i_track_zero = 1'h1;
		i_head = 1'h1;
		i_drive = 2'h2;
		run("drive", 12'h000, 2'h0, 2'h2, {8'h76, 48'h0}, 1, 8'h10);
		i_write_protect = 1'h0;
		i_track_zero = 1'h0;
	endtask

	// Non-DMA execution bytes; the late byte must report overrun.
	task automatic t_xfer;
		i_non_dma = 1'h1;
		i_xfer_to_host = 1'h1;
		run("xfer", 12'h000, 2'h0, 2'h3, {8'h06, 8'h10, 8'h00, i_res_id}, 7, 8'h70);
		i_non_dma = 1'h0;
		i_xfer_to_host = 1'h0;
	endtask

	// Main sequence.
	initial
	begin
		repeat (8) @(negedge i_clk);
		i_reset = 1'h0;
		t_regs;
		repeat (2) @(negedge i_clk);
		t_dkr;
		t_full;
		t_clear;
		t_sense;
		t_st3;
		t_xfer;
		host.wr(3'h2, 8'h04);
		check({4'h0, o_motor_en}, 8'h00);
		summarize;
	end
endmodule // testbench

bind frsh_core frsh_chk u_chk
(
	.i_clk, .i_reset, .i_cs_n, .i_rd_n, .i_wr_n, .i_addr, .i_data,
	.o_data, .o_data_oe_n, .o_drive_sel, .o_core_reset, .o_data_rate,
	.o_disk_changed, .i_media_change_n, .o_exec_start
);
